// ==== hdl/jtsm_pkg.sv ====
package jtsm_pkg;

  // Instruction register layout and codes
  localparam int IR_W = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_IDCODE = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  // Fixed pattern loaded on instruction capture
  localparam logic [2:0] IR_CAPTURE = 3'h4;

  // Identification register layout
  localparam int ID_W = 32;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_PART_LSB = 12;
  localparam int ID_REV_LSB = 28;

  // Boundary register length
  localparam int BSR_W = 98;

  // Consecutive high test-mode-select edges that force the reset state
  localparam int RESET_EDGES = 5;

  // Test clock period in the bench, and the system clock period
  localparam int TCK_PERIOD_NS = 125;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TCK_CYCLES = TCK_PERIOD_NS / CLK_PERIOD_NS;

  // Controller states
  typedef enum logic [3:0] {
    JTSM_RESET,
    JTSM_IDLE,
    JTSM_SEL_DR,
    JTSM_CAP_DR,
    JTSM_SHIFT_DR,
    JTSM_EXIT1_DR,
    JTSM_PAUSE_DR,
    JTSM_EXIT2_DR,
    JTSM_UPD_DR,
    JTSM_SEL_IR,
    JTSM_CAP_IR,
    JTSM_SHIFT_IR,
    JTSM_EXIT1_IR,
    JTSM_PAUSE_IR,
    JTSM_EXIT2_IR,
    JTSM_UPD_IR
  } jtsm_state_e;

endpackage

// ==== hdl/jtsm_tap.sv ====
`timescale 1ns/1ps

// Functional notes
// - Five or more consecutive high select samples reach test-logic-reset from any state.
// - In test-logic-reset, test logic is off, pins normal, instruction becomes IDCODE.
// - Reset state holds while select is high; low select goes to run-test/idle.
// - After reset the controller starts in test-logic-reset without any test clock edge.
// - Idle holds on low select; high select moves to select-DR.
// - Select-DR: low goes to capture-DR, high goes to select-IR.
// - Capture-DR loads pin values into boundary register under EXTEST or SAMPLE.
// - Capture-DR: high goes to exit1-DR, low goes to shift-DR.
// - Shift-DR shifts selected register toward data out; high select exits.
// - Exit1-DR: high goes to update-DR, low goes to pause-DR.
// - Pause-DR halts shifting while low; high goes to exit2-DR.
// - Exit2-DR: high goes to update-DR, low resumes shift-DR.
// - Update-DR latches boundary shift stages to parallel output on falling edge.
// - Select-IR: low goes to capture-IR, high returns to test-logic-reset.
// - Capture-IR loads fixed pattern 100 into instruction shift stages.
// - Capture-IR: high goes to exit1-IR, low goes to shift-IR.
// - Shift-IR shifts the instruction stages between data in and out.
// - Exit1-IR: high goes to update-IR, low goes to pause-IR.
// - Pause-IR halts shifting while low; high goes to exit2-IR.
// - Exit2-IR: high goes to update-IR, low resumes shift-IR.
// - Idle, select, exit and pause states leave instruction and data registers unchanged.
// - Update-IR makes shifted instruction current on falling edge; data registers kept.
// - Three-bit instruction, LSB first: 000 EXTEST, 100 SAMPLE, 110 IDCODE, 111 BYPASS.
// - Bypass puts one bit between data in and data out.
// - Identification register is 32 bits, bit 0 one, shifted LSB first.
module jtsm_tap
  import jtsm_pkg::*;
#(
  parameter int BSR_LEN = BSR_W,
  parameter logic [10:0] MAKER_ID = 11'h0a5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h1234, // Arbitrary value
  parameter logic [3:0] REV_ID = 4'h1 // Arbitrary value
) (
  // System clock, enable and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Test port pins, asynchronous to i_clk
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // Boundary cells toward the device pins
  input wire logic [BSR_LEN-1:0] i_pin_values,
  output logic [BSR_LEN-1:0] o_bsr_parallel,
  output logic o_test_mode,
  // Controller status
  output logic [2:0] o_instr,
  output logic [3:0] o_state
);

  // Three-stage samplers for the pins
  logic [2:0] tck_sync_r;
  logic [2:0] tms_sync_r;
  logic [2:0] tdi_sync_r;
  logic tck_lvl_r;
  logic tms_lvl_r;
  logic tdi_lvl_r;
  logic tck_rise;
  logic tck_fall;

  jtsm_state_e state_r;
  jtsm_state_e state_nxt;
  logic [2:0] ir_shift_r;
  logic [2:0] ir_cur_r;
  logic bypass_r;
  logic [ID_W-1:0] id_shift_r;
  logic [BSR_LEN-1:0] bsr_shift_r;
  logic [BSR_LEN-1:0] bsr_par_r;
  logic tdo_r;
  logic tdo_oe_r;
  logic [2:0] tms_high_cnt_r;

  // Identification word with bit 0 fixed at one
  function automatic logic [ID_W-1:0] id_word();
    id_word = {REV_ID, PART_ID, MAKER_ID, 1'b1};
  endfunction

  // Selected data register serial output, decoded from the current instruction
  function automatic logic dr_serial_out(input logic [2:0] instr, input logic bp,
                                         input logic id0, input logic bs0);
    case (instr)
      IR_EXTEST, IR_SAMPLE: dr_serial_out = bs0;
      IR_IDCODE: dr_serial_out = id0;
      default: dr_serial_out = bp; // Unused codes fall back to bypass
    endcase
  endfunction

  // Boundary register is the data register under both boundary instructions
  function automatic logic bsr_selected(input logic [2:0] instr);
    bsr_selected = (instr == IR_EXTEST) || (instr == IR_SAMPLE);
  endfunction

  // Sampler: a change counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tck_sync_r <= 3'h0;
      tms_sync_r <= 3'h7;
      tdi_sync_r <= 3'h0;
      tck_lvl_r <= 1'b0;
      tms_lvl_r <= 1'b1;
      tdi_lvl_r <= 1'b0;
    end else if (i_ce) begin
      tck_sync_r <= {tck_sync_r[1:0], i_tck};
      tms_sync_r <= {tms_sync_r[1:0], i_tms};
      tdi_sync_r <= {tdi_sync_r[1:0], i_tdi};
      if (tck_sync_r[1] == tck_sync_r[2]) tck_lvl_r <= tck_sync_r[2];
      if (tms_sync_r[1] == tms_sync_r[2]) tms_lvl_r <= tms_sync_r[2];
      if (tdi_sync_r[1] == tdi_sync_r[2]) tdi_lvl_r <= tdi_sync_r[2];
    end
  end

  // Edges of the filtered test clock; TMS and TDI settle long before them
  assign tck_rise = i_ce && (tck_sync_r[1] == tck_sync_r[2]) && tck_sync_r[2] && !tck_lvl_r;
  assign tck_fall = i_ce && (tck_sync_r[1] == tck_sync_r[2]) && !tck_sync_r[2] && tck_lvl_r;

  // Next state on a rising test clock edge
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      JTSM_RESET: state_nxt = tms_lvl_r ? JTSM_RESET : JTSM_IDLE;
      JTSM_IDLE: state_nxt = tms_lvl_r ? JTSM_SEL_DR : JTSM_IDLE;
      JTSM_SEL_DR: state_nxt = tms_lvl_r ? JTSM_SEL_IR : JTSM_CAP_DR;
      JTSM_CAP_DR: state_nxt = tms_lvl_r ? JTSM_EXIT1_DR : JTSM_SHIFT_DR;
      JTSM_SHIFT_DR: state_nxt = tms_lvl_r ? JTSM_EXIT1_DR : JTSM_SHIFT_DR;
      JTSM_EXIT1_DR: state_nxt = tms_lvl_r ? JTSM_UPD_DR : JTSM_PAUSE_DR;
      JTSM_PAUSE_DR: state_nxt = tms_lvl_r ? JTSM_EXIT2_DR : JTSM_PAUSE_DR;
      JTSM_EXIT2_DR: state_nxt = tms_lvl_r ? JTSM_UPD_DR : JTSM_SHIFT_DR;
      JTSM_UPD_DR: state_nxt = tms_lvl_r ? JTSM_SEL_DR : JTSM_IDLE;
      JTSM_SEL_IR: state_nxt = tms_lvl_r ? JTSM_RESET : JTSM_CAP_IR;
      JTSM_CAP_IR: state_nxt = tms_lvl_r ? JTSM_EXIT1_IR : JTSM_SHIFT_IR;
      JTSM_SHIFT_IR: state_nxt = tms_lvl_r ? JTSM_EXIT1_IR : JTSM_SHIFT_IR;
      JTSM_EXIT1_IR: state_nxt = tms_lvl_r ? JTSM_UPD_IR : JTSM_PAUSE_IR;
      JTSM_PAUSE_IR: state_nxt = tms_lvl_r ? JTSM_EXIT2_IR : JTSM_PAUSE_IR;
      JTSM_EXIT2_IR: state_nxt = tms_lvl_r ? JTSM_UPD_IR : JTSM_SHIFT_IR;
      JTSM_UPD_IR: state_nxt = tms_lvl_r ? JTSM_SEL_DR : JTSM_IDLE;
      default: state_nxt = JTSM_RESET;
    endcase
  end

  // State register; system reset stands in for power-up
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= JTSM_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // Counts consecutive high samples, for checking only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tms_high_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_lvl_r) tms_high_cnt_r <= 3'h0;
      else if (tms_high_cnt_r != 3'h7) tms_high_cnt_r <= tms_high_cnt_r + 3'h1;
    end
  end

  // Instruction shift stages; LSB leaves first, new bit enters at the top
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ir_shift_r <= IR_CAPTURE;
    end else if (tck_rise) begin
      if (state_r == JTSM_CAP_IR) ir_shift_r <= IR_CAPTURE;
      else if (state_r == JTSM_SHIFT_IR) ir_shift_r <= {tdi_lvl_r, ir_shift_r[2:1]};
    end
  end

  // Current instruction; updated on the falling edge in update-IR, forced to IDCODE in test-logic-reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ir_cur_r <= IR_IDCODE;
    end else if (i_ce && state_r == JTSM_RESET) begin
      ir_cur_r <= IR_IDCODE;
    end else if (tck_fall && state_r == JTSM_UPD_IR) begin
      ir_cur_r <= ir_shift_r;
    end
  end

  // Data registers: only the selected one captures or shifts
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bypass_r <= 1'b0;
      id_shift_r <= '0;
      bsr_shift_r <= '0;
    end else if (tck_rise) begin
      case (state_r)
        JTSM_CAP_DR: begin
          if (bsr_selected(ir_cur_r)) bsr_shift_r <= i_pin_values;
          else if (ir_cur_r == IR_IDCODE) id_shift_r <= id_word();
          else bypass_r <= 1'b0;
        end
        JTSM_SHIFT_DR: begin
          if (bsr_selected(ir_cur_r))
            bsr_shift_r <= {tdi_lvl_r, bsr_shift_r[BSR_LEN-1:1]};
          else if (ir_cur_r == IR_IDCODE) id_shift_r <= {tdi_lvl_r, id_shift_r[ID_W-1:1]};
          else bypass_r <= tdi_lvl_r;
        end
        default: begin
          bypass_r <= bypass_r;
        end
      endcase
    end
  end

  // Latched parallel boundary output, cleared by system reset only; test-logic-reset keeps its value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bsr_par_r <= '0;
    end else if (tck_fall && state_r == JTSM_UPD_DR &&
                 bsr_selected(ir_cur_r)) begin
      bsr_par_r <= bsr_shift_r;
    end
  end

  // Data out moves on the falling edge so the tester samples a stable bit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (state_r == JTSM_SHIFT_DR) || (state_r == JTSM_SHIFT_IR);
      if (state_r == JTSM_SHIFT_IR) tdo_r <= ir_shift_r[0];
      else tdo_r <= dr_serial_out(ir_cur_r, bypass_r, id_shift_r[0], bsr_shift_r[0]);
    end
  end

  // Outputs
  assign o_tdo = tdo_r;
  assign o_tdo_oe = tdo_oe_r;
  assign o_bsr_parallel = bsr_par_r;
  assign o_test_mode = (ir_cur_r == IR_EXTEST) && (state_r != JTSM_RESET);
  assign o_instr = ir_cur_r;
  assign o_state = state_r;

  // Five high samples always land in reset
  a_five_high_reset: assert property (@(posedge i_clk) disable iff (i_reset)
    (tms_high_cnt_r >= 3'(RESET_EDGES)) |-> (state_r == JTSM_RESET))
    else $error("Five high samples did not reach reset");

  a_reset_loads_id: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == JTSM_RESET && i_ce) |=> (ir_cur_r == IR_IDCODE))
    else $error("Reset state did not load the identification instruction");

  a_idle_low_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_IDLE && !tms_lvl_r) |=> (state_r == JTSM_IDLE))
    else $error("Idle left on low select");

  a_capir_pattern: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_IR) |=> (ir_shift_r == 3'h4))
    else $error("Instruction capture pattern wrong");

  a_selir_high_reset: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_SEL_IR && tms_lvl_r) |=> (state_r == JTSM_RESET))
    else $error("Select-IR high did not return to reset");

  a_instr_stable: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r != JTSM_UPD_IR && state_r != JTSM_RESET && $past(state_r) != JTSM_RESET)
      |=> $stable(ir_cur_r) || $past(state_r) == JTSM_UPD_IR)
    else $error("Instruction changed outside update");

  a_bsr_par_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r != JTSM_UPD_DR) |=> $stable(bsr_par_r))
    else $error("Boundary output changed outside update-DR");

  a_tdo_enable: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_fall && state_r != JTSM_SHIFT_DR && state_r != JTSM_SHIFT_IR) |=> !o_tdo_oe)
    else $error("Data out driven outside shift states");

  a_pause_holds: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == JTSM_PAUSE_DR) |=> $stable(bsr_shift_r) && $stable(id_shift_r))
    else $error("Data register moved during pause");

  // One check each for eleven of the state branches that the bench walks through
  a_reset_high_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_RESET && tms_lvl_r) |=> (state_r == JTSM_RESET))
    else $error("Reset state left on high select");

  a_reset_low_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_RESET && !tms_lvl_r) |=> (state_r == JTSM_IDLE))
    else $error("Reset state did not move to idle on low select");

  a_idle_high_seldr: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_IDLE && tms_lvl_r) |=> (state_r == JTSM_SEL_DR))
    else $error("Idle did not move to select-DR on high select");

  a_seldr_low_cap: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_SEL_DR && !tms_lvl_r) |=> (state_r == JTSM_CAP_DR))
    else $error("Select-DR low did not enter capture-DR");

  a_capdr_low_shift: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_DR && !tms_lvl_r) |=> (state_r == JTSM_SHIFT_DR))
    else $error("Capture-DR low did not enter shift-DR");

  a_shiftdr_low_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_SHIFT_DR && !tms_lvl_r) |=> (state_r == JTSM_SHIFT_DR))
    else $error("Shift-DR left on low select");

  a_exit1dr_high_upd: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_EXIT1_DR && tms_lvl_r) |=> (state_r == JTSM_UPD_DR))
    else $error("Exit1-DR high did not enter update-DR");

  a_exit2dr_low_shift: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_EXIT2_DR && !tms_lvl_r) |=> (state_r == JTSM_SHIFT_DR))
    else $error("Exit2-DR low did not resume shift-DR");

  a_capir_low_shift: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_IR && !tms_lvl_r) |=> (state_r == JTSM_SHIFT_IR))
    else $error("Capture-IR low did not enter shift-IR");

  a_exit1ir_high_upd: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_EXIT1_IR && tms_lvl_r) |=> (state_r == JTSM_UPD_IR))
    else $error("Exit1-IR high did not enter update-IR");

  a_exit2ir_low_shift: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_EXIT2_IR && !tms_lvl_r) |=> (state_r == JTSM_SHIFT_IR))
    else $error("Exit2-IR low did not resume shift-IR");

  // Registers that must hold, or load a fixed value
  a_pauseir_holds: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == JTSM_PAUSE_IR) |=> $stable(ir_shift_r))
    else $error("Instruction stages moved during pause");

  a_idle_holds: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == JTSM_IDLE) |=> $stable(ir_cur_r) && $stable(bsr_shift_r) && $stable(id_shift_r))
    else $error("Registers moved in idle");

  a_bypass_capture: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_DR && ir_cur_r == IR_BYPASS) |=> !bypass_r)
    else $error("Bypass bit did not capture zero");

  a_idcode_capture: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_DR && ir_cur_r == IR_IDCODE) |=> id_shift_r[0])
    else $error("Identification word bit zero not one");

  // Capture takes the pins as they stood at the detected edge, not a later copy
  a_bsr_capture: assert property (@(posedge i_clk) disable iff (i_reset)
    (tck_rise && state_r == JTSM_CAP_DR && bsr_selected(ir_cur_r)) |=>
      (bsr_shift_r == $past(i_pin_values)))
    else $error("Boundary capture missed the pin values");

endmodule // jtsm_tap

// ==== testbench/jtsm_tester.sv ====
`timescale 1ns/1ps
// Tester model: paces the test port pins from the system clock
module jtsm_tester (
  // Pacing clock
  input wire logic i_clk,
  // Test port pins
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  // Test clock stands low between steps, so it only moves inside a frame
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One test clock period of 25 system clocks; tdo taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clk);
    #1;
    o_tms = tms;
    o_tdi = tdi;
    repeat (12) @(posedge i_clk);
    #1;
    tdo = i_tdo_oe ? i_tdo : ~i_tdo; // Undriven line reads as garbage, not the last bit
    o_tck = 1'b1;
    repeat (12) @(posedge i_clk); // High 12, low 13 system clocks
    #1;
    o_tck = 1'b0;
  endtask
endmodule // jtsm_tester

// ==== testbench/jtag_tap_state_machine_tb.sv ====
`timescale 1ns/1ps
module jtag_tap_state_machine_tb;
  import jtsm_pkg::*;
  logic i_clk, i_reset, i_ce, tck, tms, tdi, tdo, oe, tmode, b;
  logic [BSR_W-1:0] pins, par, pat, got;
  logic [2:0] instr, rcode;
  logic [3:0] state;
  logic [31:0] q;
  int seed, n_mismatch, cmp_count, i;
  logic [2:0] codes [4] = '{IR_EXTEST, IR_SAMPLE, IR_BYPASS, IR_IDCODE};

  jtsm_tap dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(oe), .i_pin_values(pins),
    .o_bsr_parallel(par), .o_test_mode(tmode), .o_instr(instr), .o_state(state));
  jtsm_tester tester (.i_clk(i_clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .i_tdo(tdo), .i_tdo_oe(oe));

  // System clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Shared compare
  task automatic chk(string what, logic [BSR_W-1:0] exp, logic [BSR_W-1:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Expected identification word from the instance parameters
  function automatic logic [31:0] id_word();
    return {4'h1, 16'h1234, 11'h0a5, 1'b1};
  endfunction
  // Send n select levels, first one in bit 0
  task automatic walk(input logic [7:0] seq, input int n);
    for (int k = 0; k < n; k++) tester.step(seq[k], 1'b0, b);
  endtask
  // Shift n bits of pat from offset off; the last step leaves to exit1
  task automatic shift(input int n, input int off);
    for (int k = 0; k < n; k++) begin
      tester.step(k == n - 1, pat[off+k], b);
      got[off+k] = b;
    end
  endtask
  // Let falling-edge updates land
  task automatic settle();
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  task automatic fill();
    for (i = 0; i < BSR_W; i++) begin
      q = $random(seed);
      pat[i] = q[0];
    end
  endtask
  // Instruction load from idle, back to idle
  task automatic load_ir(input logic [2:0] code);
    walk(8'h03, 4);
    pat[2:0] = code;
    shift(3, 0);
    chk("ir capture", 3'h4, got[2:0]);
    walk(8'h01, 2);
    settle();
    chk("instr", code, instr);
    chk("test mode", code == IR_EXTEST, tmode);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    results();
  end

  initial begin
    seed = 85328;
    n_mismatch = 0;
    cmp_count = 0;
    i_reset = 1'b1;
    i_ce = 1'b1;
    pins = '0;
    repeat (16) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("state", JTSM_RESET, state);
    chk("instr", IR_IDCODE, instr);
    chk("oe", 1'b0, oe);
    walk(8'h02, 2);
    chk("state", JTSM_SEL_DR, state);
    walk(8'h03, 2);
    chk("state", JTSM_RESET, state);
    $display("test walk done");
    // Identification read straight after reset
    fill();
    walk(8'h02, 4);
    settle();
    chk("oe", 1'b1, oe);
    shift(32, 0);
    chk("id", id_word(), got[31:0]);
    walk(8'h01, 2);
    settle();
    chk("par", '0, par);
    $display("test id done");
    // Every instruction code
    foreach (codes[j]) load_ir(codes[j]);
    $display("test codes done");
    // Bypass delay of one period
    load_ir(IR_BYPASS);
    fill();
    walk(8'h01, 3);
    shift(16, 0);
    chk("bypass", {pat[14:0], 1'b0}, got[15:0]);
    walk(8'h01, 2);
    $display("test bypass done");
    // Boundary capture, pause mid-scan, update
    load_ir(IR_SAMPLE);
    fill();
    pins = pat;
    fill();
    walk(8'h01, 3);
    shift(50, 0);
    walk(8'h04, 4);
    chk("state", JTSM_SHIFT_DR, state);
    shift(48, 50);
    chk("capture", pins, got);
    chk("par", '0, par);
    walk(8'h01, 2);
    settle();
    chk("par", pat, par);
    $display("test boundary done");
    // Five high edges from mid-scan reach reset
    load_ir(IR_EXTEST);
    walk(8'h01, 3);
    walk(8'h1f, 5);
    settle();
    chk("state", JTSM_RESET, state);
    chk("instr", IR_IDCODE, instr);
    chk("test mode", 1'b0, tmode);
    chk("par", {1'b0, pins[BSR_W-1:1]}, par);
    walk(8'h01, 1);
    chk("state", JTSM_RESET, state);
    walk(8'h00, 1);
    chk("state", JTSM_IDLE, state);
    $display("test escape done");
    // A test clock pulse while the enable is low must move nothing
    i_ce = 1'b0;
    walk(8'h01, 1);
    i_ce = 1'b1;
    settle();
    chk("state", JTSM_IDLE, state);
    chk("instr", IR_IDCODE, instr);
    $display("test freeze done");
    // Random instruction loaded with a pause in the middle of the scan
    q = $random(seed);
    rcode = codes[q[1:0]];
    walk(8'h03, 4);
    pat[2:0] = rcode;
    shift(2, 0);
    walk(8'h04, 4);
    chk("state", JTSM_SHIFT_IR, state);
    shift(1, 2);
    chk("ir capture", 3'h4, got[2:0]);
    walk(8'h01, 2);
    settle();
    chk("instr", rcode, instr);
    $display("test pause ir done");
    // Second reset in mid-run, test clock held low
    i_reset = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("state", JTSM_RESET, state);
    chk("instr", IR_IDCODE, instr);
    chk("par", '0, par);
    chk("oe", 1'b0, oe);
    walk(8'h02, 2);
    chk("state", JTSM_SEL_DR, state);
    $display("test reset done");
    results();
  end
endmodule // jtag_tap_state_machine_tb
